/* File: shared/mbm_pkg.sv */
// Constants and types shared by the mailbox and bus-matching port logic.
package mbm_pkg;

	// ==========================================================================
	// Data path widths
	// ==========================================================================
	localparam int          DATA_W    = 36;
	localparam int          WORD_W    = 18;
	localparam int          LANE_W    = 9;
	localparam int          IDX_W     = 2;
	localparam int          SH_W      = 6;

	// Usable-width masks for the three Port B sizes.
	localparam logic [35:0] MASK_LONG = 36'hF_FFFF_FFFF;
	localparam logic [35:0] MASK_WORD = 36'h0_0003_FFFF;
	localparam logic [35:0] MASK_BYTE = 36'h0_0000_01FF;

	// Portions per long word, less one, for each size.
	localparam logic [1:0]  LAST_LONG = 2'h0;
	localparam logic [1:0]  LAST_WORD = 2'h1;
	localparam logic [1:0]  LAST_BYTE = 2'h3;

	// Shift step per portion position.
	localparam logic [5:0]  STEP_WORD = 6'h12;
	localparam logic [5:0]  STEP_BYTE = 6'h09;

	// ==========================================================================
	// Reset values
	// ==========================================================================
	localparam logic        FLAG_IDLE = 1'b1;
	localparam logic [1:0]  IDX_RST   = 2'h0;
	localparam logic [35:0] DATA_RST  = 36'h0_0000_0000;

	// ==========================================================================
	// Port B sizes
	// ==========================================================================
	typedef enum logic [1:0] {
		MBM_SIZE_LONG = 2'b00,
		MBM_SIZE_WORD = 2'b01,
		MBM_SIZE_BYTE = 2'b10
	} mbm_size_t;

endpackage : mbm_pkg

/* File: src/mbm_port.sv */
// Mailbox bypass registers and Port B bus matching around the two 36-bit queues.
`timescale 1ns/10ps
`default_nettype none

module mbm_port
	import mbm_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        nrst,
	input  wire logic        clk_en,
	input  wire logic        a_to_b_master_reset_n,
	input  wire logic        b_to_a_master_reset_n,
	input  wire logic        bus_match_select,
	input  wire logic        width_select,
	input  wire logic        endian_select,
	input  wire logic        port_a_chip_select_n,
	input  wire logic        port_a_write_not_read,
	input  wire logic        port_a_transfer_enable,
	input  wire logic        port_a_mail_select,
	input  wire logic [35:0] port_a_data_in,
	output logic      [35:0] port_a_data_out,
	output logic             port_a_data_oe_n,
	input  wire logic [35:0] port_a_queue_out,
	input  wire logic        port_b_chip_select_n,
	input  wire logic        port_b_read_not_write,
	input  wire logic        port_b_transfer_enable,
	input  wire logic        port_b_mail_select,
	input  wire logic [35:0] port_b_data_in,
	output logic      [35:0] port_b_data_out,
	output logic             port_b_data_oe_n,
	output logic             a_to_b_mail_flag_n,
	output logic             b_to_a_mail_flag_n,
	input  wire logic [35:0] a_to_b_queue_rd_data,
	input  wire logic        a_to_b_queue_rd_avail,
	output logic             a_to_b_queue_rd_en,
	input  wire logic        port_b_full_or_in_ready,
	output logic      [35:0] b_to_a_queue_wr_data,
	output logic             b_to_a_queue_wr_en,
	output logic      [1:0]  port_b_size,
	output logic             big_endian_active
);

	// ==========================================================================
	// State
	// ==========================================================================
	mbm_size_t   size_q;
	logic        big_q;
	logic        mrs_both_q;
	logic        a_to_b_mail_register_flag_n_q;
	logic        b_to_a_mail_register_flag_n_q;
	logic [35:0] a_to_b_mail_register_q;
	logic [35:0] b_to_a_mail_register_q;
	logic [35:0] rd_hold_q;
	logic [35:0] rd_out_q;
	logic [1:0]  rd_idx_q;
	logic [35:0] wr_asm_q;
	logic [1:0]  wr_idx_q;
	logic [35:0] wr_data_q;
	logic        wr_en_q;

	// ==========================================================================
	// Configuration decode
	// ==========================================================================
	// Size requested by the static select pins; only sampled at reset end.
	mbm_size_t   size_pins;
	logic        mrs_both;
	logic        mrs_rise;
	logic        in_reset;

	assign size_pins = !bus_match_select ? MBM_SIZE_LONG :
		(width_select ? MBM_SIZE_BYTE : MBM_SIZE_WORD);
	assign mrs_both  = a_to_b_master_reset_n & b_to_a_master_reset_n;
	assign mrs_rise  = mrs_both & !mrs_both_q;
	assign in_reset  = !mrs_both;

	// Per-size mask, last portion index and shift step.
	logic [35:0] width_mask;
	logic [1:0]  last_idx;
	logic [5:0]  step;

	assign width_mask = (size_q == MBM_SIZE_LONG) ? MASK_LONG :
		((size_q == MBM_SIZE_WORD) ? MASK_WORD : MASK_BYTE);
	assign last_idx   = (size_q == MBM_SIZE_LONG) ? LAST_LONG :
		((size_q == MBM_SIZE_WORD) ? LAST_WORD : LAST_BYTE);
	assign step       = (size_q == MBM_SIZE_WORD) ? STEP_WORD : STEP_BYTE;

	// Endian only matters for narrow sizes; long mode ignores it entirely.
	logic        big_eff;

	assign big_eff = big_q & (size_q != MBM_SIZE_LONG);

	// ==========================================================================
	// Port request decode
	// ==========================================================================
	logic a_sel;
	logic a_wr;
	logic a_rd;
	logic b_sel;
	logic b_wr;
	logic b_rd;

	assign a_sel = !port_a_chip_select_n & port_a_transfer_enable;
	assign a_wr  = a_sel & port_a_write_not_read;
	assign a_rd  = a_sel & !port_a_write_not_read;
	assign b_sel = !port_b_chip_select_n & port_b_transfer_enable;
	assign b_wr  = b_sel & !port_b_read_not_write;
	assign b_rd  = b_sel & port_b_read_not_write;

	// Mail strobes; a write is only taken while the flag is still high.
	logic a_to_b_mail_register_wr;
	logic b_to_a_mail_register_wr;
	logic a_to_b_mail_register_rd;
	logic b_to_a_mail_register_rd;

	assign a_to_b_mail_register_wr = a_wr & port_a_mail_select & a_to_b_mail_register_flag_n_q;
	assign b_to_a_mail_register_wr = b_wr & port_b_mail_select & b_to_a_mail_register_flag_n_q;
	assign a_to_b_mail_register_rd = b_rd & port_b_mail_select;
	assign b_to_a_mail_register_rd = a_rd & port_a_mail_select;

	// Queue strobes on Port B; mail select low routes to the queues.
	logic q_rd;
	logic q_wr;

	assign q_rd = b_rd & !port_b_mail_select & !in_reset;
	assign q_wr = b_wr & !port_b_mail_select & port_b_full_or_in_ready & !in_reset;

	// ==========================================================================
	// Read-side unpacking
	// ==========================================================================
	// A new long word is fetched only when the previous one is used up.
	logic        fetch;
	logic [1:0]  rd_pos;
	logic [5:0]  rd_sh;
	logic [35:0] rd_src;
	logic [35:0] rd_part;
	logic [1:0]  rd_idx_d;

	assign fetch    = q_rd & (rd_idx_q == IDX_RST) & a_to_b_queue_rd_avail;
	assign rd_pos   = big_eff ? (last_idx - rd_idx_q) : rd_idx_q;
	assign rd_sh    = (size_q == MBM_SIZE_LONG) ? 6'h00 : 6'(rd_pos * step);
	assign rd_src   = (rd_idx_q == IDX_RST) ? a_to_b_queue_rd_data : rd_hold_q;
	assign rd_part  = (rd_src >> rd_sh) & width_mask;
	assign rd_idx_d = (rd_idx_q == last_idx) ? IDX_RST : rd_idx_q + 2'h1;

	logic rd_step;

	assign rd_step            = fetch | (q_rd & (rd_idx_q != IDX_RST));
	assign a_to_b_queue_rd_en = fetch;

	// ==========================================================================
	// Write-side packing
	// ==========================================================================
	// Each portion lands at its lane position; the last one commits the word.
	logic [1:0]  wr_pos;
	logic [5:0]  wr_sh;
	logic [35:0] wr_ins;
	logic [35:0] wr_asm_d;
	logic        wr_last;

	assign wr_pos   = big_eff ? (last_idx - wr_idx_q) : wr_idx_q;
	assign wr_sh    = (size_q == MBM_SIZE_LONG) ? 6'h00 : 6'(wr_pos * step);
	assign wr_ins   = (port_b_data_in & width_mask) << wr_sh;
	assign wr_asm_d = (wr_asm_q & ~(width_mask << wr_sh)) | wr_ins;
	assign wr_last  = (wr_idx_q == last_idx);

	// ==========================================================================
	// Configuration latch
	// ==========================================================================
	// Size and endian are caught on the release of both master resets so a
	// glitch on the static pins during traffic cannot re-order a word.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			mrs_both_q <= 1'b0;
			size_q     <= MBM_SIZE_LONG;
			big_q      <= 1'b0;
		end else if (clk_en) begin
			mrs_both_q <= mrs_both;
			if (mrs_rise) begin
				size_q <= size_pins;
				big_q  <= endian_select;
			end
		end
	end

	// ==========================================================================
	// Mail registers
	// ==========================================================================
	// Contents change only on an accepted write; reads leave them alone and
	// no endian reordering is ever applied.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			a_to_b_mail_register_q <= DATA_RST;
			b_to_a_mail_register_q <= DATA_RST;
		end else if (clk_en) begin
			if (a_to_b_mail_register_wr) begin
				a_to_b_mail_register_q <= port_a_data_in & width_mask;
			end
			if (b_to_a_mail_register_wr) begin
				b_to_a_mail_register_q <= port_b_data_in & width_mask;
			end
		end
	end

	// Mail flags: a write that lands with a read of the same box wins, so
	// fresh mail is never reported as collected.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			a_to_b_mail_register_flag_n_q <= FLAG_IDLE;
			b_to_a_mail_register_flag_n_q <= FLAG_IDLE;
		end else if (clk_en) begin
			if (in_reset) begin
				a_to_b_mail_register_flag_n_q <= FLAG_IDLE;
				b_to_a_mail_register_flag_n_q <= FLAG_IDLE;
			end else begin
				if (a_to_b_mail_register_wr) begin
					a_to_b_mail_register_flag_n_q <= 1'b0;
				end else if (a_to_b_mail_register_rd) begin
					a_to_b_mail_register_flag_n_q <= FLAG_IDLE;
				end
				if (b_to_a_mail_register_wr) begin
					b_to_a_mail_register_flag_n_q <= 1'b0;
				end else if (b_to_a_mail_register_rd) begin
					b_to_a_mail_register_flag_n_q <= FLAG_IDLE;
				end
			end
		end
	end

	// ==========================================================================
	// Port B read path
	// ==========================================================================
	// The fetched long word is kept whole; later reads slice the rest out.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rd_hold_q <= DATA_RST;
			rd_out_q  <= DATA_RST;
			rd_idx_q  <= IDX_RST;
		end else if (clk_en) begin
			if (in_reset) begin
				rd_idx_q <= IDX_RST;
			end else if (rd_step) begin
				if (fetch) begin
					rd_hold_q <= a_to_b_queue_rd_data;
				end
				rd_out_q <= rd_part;
				rd_idx_q <= rd_idx_d;
			end
		end
	end

	// ==========================================================================
	// Port B write path
	// ==========================================================================
	// Partial words wait in the assembly register; the queue only ever sees
	// complete long words.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			wr_asm_q  <= DATA_RST;
			wr_idx_q  <= IDX_RST;
			wr_data_q <= DATA_RST;
			wr_en_q   <= 1'b0;
		end else if (clk_en) begin
			wr_en_q <= 1'b0;
			if (in_reset) begin
				wr_idx_q <= IDX_RST;
			end else if (q_wr) begin
				wr_asm_q <= wr_asm_d;
				if (wr_last) begin
					wr_data_q <= wr_asm_d;
					wr_en_q   <= 1'b1;
					wr_idx_q  <= IDX_RST;
				end else begin
					wr_idx_q <= wr_idx_q + 2'h1;
				end
			end
		end
	end

	// ==========================================================================
	// Outputs
	// ==========================================================================
	// Drivers are on only during a selected read; the mail select steers
	// between the queue data (rd_out_q on Port B, port_a_queue_out on Port A) and the mail register.
	assign port_a_data_oe_n     = !(!port_a_chip_select_n & !port_a_write_not_read);
	assign port_b_data_oe_n     = !(!port_b_chip_select_n & port_b_read_not_write);
	assign port_a_data_out      = port_a_mail_select ? b_to_a_mail_register_q : port_a_queue_out;
	assign port_b_data_out      = port_b_mail_select ? a_to_b_mail_register_q : rd_out_q;
	assign a_to_b_mail_flag_n   = a_to_b_mail_register_flag_n_q;
	assign b_to_a_mail_flag_n   = b_to_a_mail_register_flag_n_q;
	assign b_to_a_queue_wr_data = wr_data_q;
	assign b_to_a_queue_wr_en   = wr_en_q & clk_en;
	assign port_b_size          = size_q;
	assign big_endian_active    = big_eff;

endmodule : mbm_port

`default_nettype wire

/* File: verification/mbm_port_monitor.sv */
// Concurrent checks on the mailbox and bus-matching port pins.
`timescale 1ns/10ps
`default_nettype none
module mbm_port_monitor
	import mbm_pkg::*;
(
	input wire logic        mclk,
	input wire logic        nrst,
	input wire logic        clk_en,
	input wire logic        a_to_b_master_reset_n,
	input wire logic        b_to_a_master_reset_n,
	input wire logic        port_a_chip_select_n,
	input wire logic        port_a_write_not_read,
	input wire logic        port_a_transfer_enable,
	input wire logic        port_a_mail_select,
	input wire logic        port_b_chip_select_n,
	input wire logic        port_b_read_not_write,
	input wire logic        port_b_transfer_enable,
	input wire logic        port_b_mail_select,
	input wire logic        port_b_full_or_in_ready,
	input wire logic        a_to_b_mail_flag_n,
	input wire logic        b_to_a_mail_flag_n,
	input wire logic        a_to_b_queue_rd_avail,
	input wire logic        a_to_b_queue_rd_en,
	input wire logic        b_to_a_queue_wr_en,
	input wire logic [1:0]  port_b_size,
	input wire logic [35:0] port_a_data_out,
	input wire logic [35:0] port_a_queue_out,
	input wire logic [35:0] port_b_data_out
);
	// ======================================================================
	// Decoded strobes
	// ======================================================================
	// Nothing is taken while a master reset is low or the clock is held, except mail data written in reset and queue fetch strobes with the clock held.
	wire logic run  = clk_en && a_to_b_master_reset_n && b_to_a_master_reset_n;
	wire logic a_on = run && !port_a_chip_select_n && port_a_transfer_enable;
	wire logic b_on = run && !port_b_chip_select_n && port_b_transfer_enable;
	wire logic a_wr = a_on && port_a_write_not_read && port_a_mail_select;
	wire logic a_rd = a_on && !port_a_write_not_read && port_a_mail_select;
	wire logic b_wr = b_on && !port_b_read_not_write && port_b_mail_select;
	wire logic b_rd = b_on && port_b_read_not_write && port_b_mail_select;
	wire logic b_qw = b_on && !port_b_read_not_write && !port_b_mail_select && port_b_full_or_in_ready;
	wire logic b_qr = b_on && port_b_read_not_write && !port_b_mail_select;
	wire logic lng  = port_b_size == MBM_SIZE_LONG;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	// ======================================================================
	// Properties
	// ======================================================================
	// Mail waiting and still selected across two cycles.
	sequence s_mail_held;
		(!a_to_b_mail_flag_n && port_b_mail_select) ##1 port_b_mail_select;
	endsequence

	mail_a_set_a: assert property (
		a_wr && a_to_b_mail_flag_n |=> !a_to_b_mail_flag_n) else $error("A mail flag not set");
	mail_b_set_a: assert property (
		b_wr && b_to_a_mail_flag_n |=> !b_to_a_mail_flag_n) else $error("B mail flag not set");
	mail_kept_a: assert property (
		s_mail_held |-> $stable(port_b_data_out)) else $error("mail changed while waiting");
	a_flag_ret_a: assert property (
		b_rd && !a_wr |=> a_to_b_mail_flag_n) else $error("A mail flag not returned");
	b_flag_ret_a: assert property (
		a_rd && !b_wr |=> b_to_a_mail_flag_n) else $error("B mail flag not returned");
	flag_reset_a: assert property (
		(!a_to_b_master_reset_n || !b_to_a_master_reset_n) && clk_en
		|=> a_to_b_mail_flag_n && b_to_a_mail_flag_n)
		else $error("flags low after master reset");
	queue_pass_a: assert property (
		!port_a_mail_select |-> port_a_data_out == port_a_queue_out) else $error("A queue path");
	commit_cause_a: assert property (
		b_to_a_queue_wr_en |-> $past(b_qw)) else $error("queue write without cause");
	long_write_a: assert property (
		lng && b_qw |=> b_to_a_queue_wr_en) else $error("long write not committed");
	long_read_a: assert property (
		lng && b_qr && a_to_b_queue_rd_avail |-> a_to_b_queue_rd_en) else $error("long fetch");
endmodule : mbm_port_monitor
`default_nettype wire

/* File: verification/mbm_queue_model.sv */
// Behavioural stand-in for the two long-word queues behind the port.
`timescale 1ns/10ps
`default_nettype none
module mbm_queue_model (
	input  wire logic        mclk,
	input  wire logic        nrst,
	input  wire logic        rd_en,
	input  wire logic        wr_en,
	input  wire logic        stall,
	input  wire logic [35:0] wr_data,
	output logic      [35:0] rd_data,
	output logic             rd_avail,
	output logic             ready
);
	// Only whole long words are queued or captured.
	logic [35:0] q[$];
	logic [35:0] got[$];
	logic [35:0] last = 36'h0;

	// A stalled queue drops ready so that writes are refused.
	assign ready = !stall;

	// Loads a head word; called off the sampling edge.
	task push(input logic [35:0] w);
		q.push_back(w);
		rd_data = q[0];
		rd_avail = 1'b1;
	endtask : push

	// Pops on the fetch strobe; an empty head shows the inverse so stale data is not mistaken.
	always @(posedge mclk) begin
		if (rd_en && q.size() != 0) begin
			last = q.pop_front();
		end
		if (wr_en) begin
			got.push_back(wr_data);
		end
		rd_avail <= nrst && q.size() != 0;
		rd_data <= (q.size() != 0) ? q[0] : ~last;
	end
endmodule : mbm_queue_model
`default_nettype wire

/* File: verification/mbm_port_tb.sv */
// Self-checking bench for the mailbox and bus-matching port.
`timescale 1ns/10ps
`default_nettype none
module mbm_port_tb
	import mbm_pkg::*;
;
	logic        mclk, nrst, clk_en, a_to_b_master_reset_n, b_to_a_master_reset_n, stall;
	logic        bus_match_select, width_select, endian_select, port_a_data_oe_n, port_b_data_oe_n;
	logic        port_a_chip_select_n, port_a_write_not_read, port_a_transfer_enable;
	logic        port_a_mail_select, port_b_chip_select_n, port_b_read_not_write;
	logic        port_b_transfer_enable, port_b_mail_select, a_to_b_mail_flag_n;
	logic        b_to_a_mail_flag_n, a_to_b_queue_rd_en, a_to_b_queue_rd_avail, b_to_a_queue_wr_en;
	logic        port_b_full_or_in_ready, big_endian_active;
	logic [35:0] port_a_data_in, port_a_data_out, port_a_queue_out, port_b_data_in;
	logic [35:0] port_b_data_out, a_to_b_queue_rd_data, b_to_a_queue_wr_data, w, msk;
	logic [1:0]  port_b_size;
	logic [2:0]  modes [5] = '{3'h1, 3'h5, 3'h4, 3'h7, 3'h6};
	int          err_total = 0, checked = 0, cyc = 0, n, wd;

	mbm_port dut (.*);
	mbm_queue_model qm (.mclk(mclk), .nrst(nrst), .rd_en(a_to_b_queue_rd_en),
		.wr_en(b_to_a_queue_wr_en), .stall(stall), .wr_data(b_to_a_queue_wr_data),
		.rd_data(a_to_b_queue_rd_data), .rd_avail(a_to_b_queue_rd_avail),
		.ready(port_b_full_or_in_ready));

	// ======================================================================
	// Helpers
	// ======================================================================
	always #2.5 mclk = ~mclk;

	// Cuts a hang short well beyond the roughly 100 cycles the tests need.
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_total = err_total + 1;
			test_done();
		end
	end

	task check(input logic [35:0] s, e);
		checked = checked + 1;
		if (s !== e) begin
			err_total = err_total + 1;
			$display("BAD %0t saw %h want %h", $time, s, e);
		end
	endtask : check

	task test_done;
		$display("compares %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : test_done

	// One transfer per call; own strobes stay up so back-to-back calls never glitch
	// them, while the other port is released so a stale request cannot land later.
	task pa(input logic wr, m, input logic [35:0] d);
		port_b_chip_select_n = 1'b1;
		port_a_write_not_read = wr;
		port_a_mail_select = m;
		port_a_data_in = d;
		port_a_chip_select_n = 1'b0;
		port_a_transfer_enable = 1'b1;
		@(negedge mclk);
	endtask : pa

	task pb(input logic rd, m, input logic [35:0] d);
		port_a_chip_select_n = 1'b1;
		port_b_read_not_write = rd;
		port_b_mail_select = m;
		port_b_data_in = d;
		port_b_chip_select_n = 1'b0;
		port_b_transfer_enable = 1'b1;
		@(negedge mclk);
	endtask : pb

	// Released data lines flip so a stale value is never read as valid.
	task idle;
		port_a_chip_select_n = 1'b1;
		port_b_chip_select_n = 1'b1;
		port_a_transfer_enable = 1'b0;
		port_b_transfer_enable = 1'b0;
		port_a_data_in = ~port_a_data_in;
		port_b_data_in = ~port_b_data_in;
		@(negedge mclk);
	endtask : idle

	// Sizes are held static outside master reset; endian latched at its release.
	task cfg(input logic [2:0] m);
		a_to_b_master_reset_n = 1'b0;
		b_to_a_master_reset_n = 1'b0;
		{bus_match_select, width_select, endian_select} = m;
		repeat (2) @(negedge mclk);
		a_to_b_master_reset_n = 1'b1;
		b_to_a_master_reset_n = 1'b1;
		@(negedge mclk);
	endtask : cfg

	function automatic logic [35:0] part(input int i);
		return (w >> (wd * (endian_select ? n - 1 - i : i))) & msk;
	endfunction : part

	// ======================================================================
	// Main sequence
	// ======================================================================
	initial begin
		mclk = 1'b0;
		nrst = 1'b0;
		clk_en = 1'b1;
		stall = 1'b0;
		port_a_queue_out = 36'h5_A5A5_A5A5;
		port_a_data_in = 36'h0_0000_0000;
		port_b_data_in = 36'h0_0000_0000;
		port_a_mail_select = 1'b0;
		port_b_mail_select = 1'b0;
		port_a_write_not_read = 1'b0;
		port_b_read_not_write = 1'b0;
		a_to_b_master_reset_n = 1'b0;
		b_to_a_master_reset_n = 1'b0;
		{bus_match_select, width_select, endian_select} = 3'h0;
		idle();
		repeat (6) @(negedge mclk);
		nrst = 1'b1;
		foreach (modes[k]) begin
			cfg(modes[k]);
			n = bus_match_select ? (width_select ? 4 : 2) : 1;
			wd = 36 / n;
			msk = (n == 1) ? MASK_LONG : (n == 2) ? MASK_WORD : MASK_BYTE;
			w = 36'h9_1B2C_3D4E ^ 36'(k);
			// Size codes count up as the portions per long word double.
			check(36'(port_b_size), 36'(n / 2));
			check(36'(big_endian_active), 36'(endian_select && n > 1));
			check(36'(a_to_b_mail_flag_n & b_to_a_mail_flag_n), 36'h1);
			pa(1'b1, 1'b1, w);
			pa(1'b1, 1'b1, ~w);
			check(36'(a_to_b_mail_flag_n), 36'h0);
			pb(1'b1, 1'b1, 36'h0);
			check(port_b_data_out & msk, w & msk);
			check(36'(a_to_b_mail_flag_n), 36'h1);
			check(36'({port_a_data_oe_n, port_b_data_oe_n}), 36'h2);
			pb(1'b1, 1'b1, 36'h0);
			check(port_b_data_out & msk, w & msk);
			pb(1'b0, 1'b1, ~w);
			check(36'(b_to_a_mail_flag_n), 36'h0);
			// A read that meets a held clock enable must not collect the mail.
			clk_en = 1'b0;
			pa(1'b0, 1'b1, 36'h0);
			check(36'(b_to_a_mail_flag_n), 36'h0);
			clk_en = 1'b1;
			pa(1'b0, 1'b1, 36'h0);
			check(port_a_data_out & msk, ~w & msk);
			check(36'(b_to_a_mail_flag_n), 36'h1);
			check(36'({port_a_data_oe_n, port_b_data_oe_n}), 36'h1);
			port_a_queue_out = ~w;
			pa(1'b0, 1'b0, 36'h0);
			check(port_a_data_out, ~w);
			idle();
			check(36'({port_a_data_oe_n, port_b_data_oe_n}), 36'h3);
			qm.push(w);
			for (int i = 0; i < n; i++) begin
				pb(1'b1, 1'b0, 36'h0);
				check(port_b_data_out & msk, part(i));
			end
			for (int i = 0; i < n; i++) begin
				if (i == 1) begin
					stall = 1'b1;
					pb(1'b0, 1'b0, ~part(i));
					stall = 1'b0;
				end
				pb(1'b0, 1'b0, part(i) | ~msk);
			end
			idle();
			check(qm.got.pop_front(), w);
			$display("test of mode %b done", modes[k]);
		end
		test_done();
	end
endmodule : mbm_port_tb

bind mbm_port mbm_port_monitor mon (.*);
`default_nettype wire
